//--- hw/pws_pkg.sv
// shared constants for the power-down / wake sequencer, both ends
package pws_pkg;
    // clock period of mclk (40 MHz)
    localparam int CLK_PERIOD_NS = 25;
    // documented times in their own units
    localparam int T_PWR_ON_NS = 1300000; // power on to reset / power-down release, least
    localparam int T_RST_PULSE_NS = 1000; // least reset pulse width
    localparam int T_PD_PULSE_NS = 10000; // least power-down pulse width
    localparam int T_SLEEP_NS = 50; // power-down assert to low power, typical
    localparam int T_WAKE_NS = 2000000; // release to clocks running / wake interrupt, typical
    localparam int T_STABLE_NS = 2100000; // release to oscillator stable, typical
    localparam int T_BUS_RDY_NS = 1000; // oscillator stable to first bus access, least
    // cycle counts: least times round up, typical device times round down
    localparam logic [16:0] PWR_ON_CYC = 17'((T_PWR_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [16:0] RST_PULSE_CYC = 17'((T_RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [16:0] PD_PULSE_CYC = 17'((T_PD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [16:0] SLEEP_CYC = 17'(T_SLEEP_NS / CLK_PERIOD_NS);
    localparam logic [16:0] WAKE_CYC = 17'(T_WAKE_NS / CLK_PERIOD_NS);
    localparam logic [16:0] STABLE_CYC = 17'(T_STABLE_NS / CLK_PERIOD_NS);
    localparam logic [16:0] BUS_RDY_CYC = 17'((T_BUS_RDY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // register offsets
    localparam logic [7:0] ADDR_CONFIG_IRQ = 8'h05;
    localparam logic [7:0] ADDR_WAKE_EN = 8'h1C;
    // config_interrupt_pin and wake_interrupt_enable fields
    localparam int CFG_POL_BIT = 0; // 1: interrupt active high, 0: active low
    localparam int CFG_DRV_BIT = 1; // 1: open drain, 0: push-pull
    localparam int WAKE_EN_BIT = 0; // 1: wake event raises the interrupt
    // reset values
    localparam logic [7:0] CONFIG_IRQ_RST = 8'h00;
    localparam logic [7:0] WAKE_EN_RST = 8'h00;
endpackage : pws_pkg

//--- hw/pws_link_if.sv
`timescale 1ns/100ps
// pins between host controller and radio device
interface pws_link_if;
    logic powerDownPin; // high: device powered down
    logic resetPinN; // low: device held in reset
    logic regWr; // one-cycle register write strobe
    logic regRd; // one-cycle register read strobe
    logic [7:0] regAddr; // register offset
    logic [7:0] regWdata; // write data
    logic [7:0] regRdata; // read data, valid with regAck
    logic regAck; // one-cycle access answer
    logic irqOut; // interrupt level driven by the device
    logic irqOe; // device drives the interrupt pin
    logic irqPin; // resolved pin, pulled up when not driven
    logic clockOutPin; // clock output of the device

    // open-drain or undriven pin floats high through the pull-up
    assign irqPin = irqOe ? irqOut : 1'b1;

    modport host (
        output powerDownPin, resetPinN, regWr, regRd, regAddr, regWdata,
        input regRdata, regAck, irqPin, clockOutPin
    );
    modport device (
        input powerDownPin, resetPinN, regWr, regRd, regAddr, regWdata,
        output regRdata, regAck, irqOut, irqOe, clockOutPin
    );
endinterface : pws_link_if

//--- hw/pws_device.sv
`timescale 1ns/100ps
module pws_device
    import pws_pkg::*;
#(
    parameter logic [16:0] WakeCyc = WAKE_CYC, // release to clocks running
    parameter logic [16:0] StableCyc = STABLE_CYC // release to oscillator stable
) (
    input wire logic mclk,
    input wire logic nrst,
    pws_link_if.device link,
    input wire logic clockOutEnable,
    output logic lowPower,
    output logic clocksRunning,
    output logic oscStable
);
    // sequencer states
    typedef enum logic [1:0] {
        DS_SLEEP = 2'b00, // power-down asserted
        DS_WAKE = 2'b01, // oscillator restarting, clocks not yet running
        DS_SETTLE = 2'b10, // clocks running, oscillator settling
        DS_RUN = 2'b11 // oscillator stable, registers reachable
    } pws_dev_state_e;

    // whole state of the device end
    typedef struct packed {
        pws_dev_state_e state; // sequencer state
        logic [16:0] cnt; // cycles since power-down edge
        logic [7:0] cfgIrq; // config_interrupt_pin
        logic [7:0] wakeEn; // wake_interrupt_enable
        logic pending; // wake interrupt pending
        logic lowPwr; // in low power mode
        logic [7:0] rdata; // read data
        logic ack; // access answer
        logic clkOut; // divided clock output
    } pws_dev_s;

    pws_dev_s st_q;
    pws_dev_s st_d;
    logic irqLevel; // active interrupt turned to pin polarity

    // next state
    always_comb begin
        st_d = st_q;
        st_d.ack = 1'b0;
        // sequencer
        if (link.powerDownPin) begin
            // power-down wins over everything else
            if (st_q.state != DS_SLEEP) begin
                st_d.state = DS_SLEEP;
                st_d.cnt = '0;
            end else if (st_q.cnt < SLEEP_CYC) begin
                st_d.cnt = st_q.cnt + 17'h00001;
            end
            // low power after the sleep delay
            if (st_q.state == DS_SLEEP && st_q.cnt + 17'h00001 >= SLEEP_CYC) begin
                st_d.lowPwr = 1'b1;
            end
        end else begin
            unique case (st_q.state)
                DS_SLEEP: begin
                    // release of power-down is the wake event
                    st_d.state = DS_WAKE;
                    st_d.cnt = 17'h00001;
                    st_d.lowPwr = 1'b0;
                end
                DS_WAKE: begin
                    st_d.cnt = st_q.cnt + 17'h00001;
                    // clocks running after the wake delay
                    if (st_q.cnt + 17'h00001 >= WakeCyc) begin
                        st_d.state = DS_SETTLE;
                        if (st_q.wakeEn[WAKE_EN_BIT]) begin
                            st_d.pending = 1'b1;
                        end
                    end
                end
                DS_SETTLE: begin
                    st_d.cnt = st_q.cnt + 17'h00001;
                    // stable 2100 us after release, 100 us after the wake interrupt
                    if (st_q.cnt + 17'h00001 >= StableCyc) begin
                        st_d.state = DS_RUN;
                    end
                end
                DS_RUN: begin
                    // hold; nothing to count
                end
            endcase
        end
        // divided clock output only while clocks run and output enabled
        if ((st_q.state == DS_SETTLE || st_q.state == DS_RUN) && clockOutEnable) begin
            st_d.clkOut = ~st_q.clkOut;
        end else begin
            st_d.clkOut = 1'b0;
        end
        // register access only when stable and out of reset
        if (st_q.state == DS_RUN && link.resetPinN && !link.powerDownPin) begin
            if (link.regWr) begin
                st_d.ack = 1'b1;
                if (link.regAddr == ADDR_CONFIG_IRQ) begin
                    st_d.cfgIrq = link.regWdata;
                end else if (link.regAddr == ADDR_WAKE_EN) begin
                    st_d.wakeEn = link.regWdata;
                end
            end else if (link.regRd) begin
                st_d.ack = 1'b1;
                if (link.regAddr == ADDR_CONFIG_IRQ) begin
                    st_d.rdata = st_q.cfgIrq;
                end else if (link.regAddr == ADDR_WAKE_EN) begin
                    // reading the wake register shows and clears the pending bit
                    st_d.rdata = {st_q.wakeEn[7:1], st_q.wakeEn[0]};
                    st_d.rdata[7] = st_q.pending;
                    st_d.pending = 1'b0;
                end else begin
                    // unmapped offset reads zero
                    st_d.rdata = 8'h00;
                end
            end
        end
        // a new wake event in the clearing cycle still sets the flag
        if (!link.powerDownPin && st_q.state == DS_WAKE && st_q.cnt + 17'h00001 >= WakeCyc
            && st_q.wakeEn[WAKE_EN_BIT]) begin
            st_d.pending = 1'b1;
        end
        // pin reset restores register defaults and drops the interrupt
        if (!link.resetPinN) begin
            st_d.cfgIrq = CONFIG_IRQ_RST;
            st_d.wakeEn = WAKE_EN_RST;
            st_d.pending = 1'b0;
            st_d.ack = 1'b0;
        end
    end

    // state register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_q.state <= DS_SLEEP;
            st_q.cnt <= '0;
            st_q.cfgIrq <= CONFIG_IRQ_RST;
            st_q.wakeEn <= WAKE_EN_RST;
            st_q.pending <= 1'b0;
            st_q.lowPwr <= 1'b1;
            st_q.rdata <= 8'h00;
            st_q.ack <= 1'b0;
            st_q.clkOut <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // interrupt pin: polarity and drive method from config
    always_comb begin
        irqLevel = st_q.cfgIrq[CFG_POL_BIT] ? st_q.pending : ~st_q.pending;
        if (st_q.cfgIrq[CFG_DRV_BIT]) begin
            // open drain pulls low only
            link.irqOut = 1'b0;
            link.irqOe = ~irqLevel;
        end else begin
            // push-pull drives both levels
            link.irqOut = irqLevel;
            link.irqOe = 1'b1;
        end
    end

    // link and status outputs
    assign link.regRdata = st_q.rdata;
    assign link.regAck = st_q.ack;
    assign link.clockOutPin = st_q.clkOut;
    assign lowPower = st_q.lowPwr;
    assign clocksRunning = (st_q.state == DS_SETTLE) || (st_q.state == DS_RUN);
    assign oscStable = (st_q.state == DS_RUN);
endmodule : pws_device

//--- hw/pws_host.sv
`timescale 1ns/100ps
// host controller end: sequences power-down and reset pins, issues accesses
module pws_host
    import pws_pkg::*;
#(
    parameter logic [16:0] PwrOnCyc = PWR_ON_CYC, // power on to pin release
    parameter logic [16:0] StableCyc = STABLE_CYC // release to oscillator stable
) (
    input wire logic mclk,
    input wire logic nrst,
    pws_link_if.host link,
    input wire logic supplyUp,
    input wire logic sleepReq,
    input wire logic resetReq,
    input wire logic usrWr,
    input wire logic usrRd,
    input wire logic [7:0] usrAddr,
    input wire logic [7:0] usrWdata,
    output logic usrReady,
    output logic [7:0] usrRdata,
    output logic usrDone,
    output logic wakeIrq
);
    // host states
    typedef enum logic [2:0] {
        HS_OFF = 3'b000, // supply down
        HS_POR = 3'b001, // power on wait, both pins held
        HS_WAKE = 3'b010, // waiting for oscillator plus bus delay
        HS_READY = 3'b011, // accesses allowed
        HS_BUSY = 3'b100, // access outstanding
        HS_SLEEP = 3'b101, // power-down asserted
        HS_RESET = 3'b110 // reset pulse
    } pws_host_state_e;

    // whole state of the host end
    typedef struct packed {
        pws_host_state_e state;
        logic [16:0] cnt; // cycles in the current state
        logic pd; // power-down pin
        logic rstN; // reset pin
        logic wr; // write strobe
        logic rd; // read strobe
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata; // captured read data
        logic done; // access finished
    } pws_host_s;

    pws_host_s st_q;
    pws_host_s st_d;

    // next state
    always_comb begin
        st_d = st_q;
        st_d.wr = 1'b0;
        st_d.rd = 1'b0;
        st_d.done = 1'b0;
        st_d.cnt = st_q.cnt + 17'h00001;
        if (!supplyUp) begin
            // supply down: power-down and reset held
            st_d.state = HS_OFF;
            st_d.pd = 1'b1;
            st_d.rstN = 1'b0;
            st_d.cnt = '0;
        end else begin
            unique case (st_q.state)
                HS_OFF: begin
                    st_d.state = HS_POR;
                    st_d.cnt = 17'h00001;
                end
                HS_POR: begin
                    // both pins released after the power on time
                    if (st_q.cnt >= PwrOnCyc) begin
                        st_d.pd = 1'b0;
                        st_d.rstN = 1'b1;
                        st_d.state = HS_WAKE;
                        st_d.cnt = 17'h00001;
                    end
                end
                HS_WAKE: begin
                    // wait oscillator stable plus bus ready delay
                    if (st_q.cnt >= StableCyc + BUS_RDY_CYC) begin
                        st_d.state = HS_READY;
                    end
                end
                HS_READY: begin
                    if (sleepReq) begin
                        st_d.pd = 1'b1;
                        st_d.state = HS_SLEEP;
                        st_d.cnt = 17'h00001;
                    end else if (resetReq) begin
                        st_d.rstN = 1'b0;
                        st_d.state = HS_RESET;
                        st_d.cnt = 17'h00001;
                    end else if (usrWr || usrRd) begin
                        st_d.wr = usrWr;
                        st_d.rd = usrRd && !usrWr;
                        st_d.addr = usrAddr;
                        st_d.wdata = usrWdata;
                        st_d.state = HS_BUSY;
                    end
                end
                HS_BUSY: begin
                    // device answers one cycle after the strobe
                    if (link.regAck) begin
                        st_d.rdata = link.regRdata;
                        st_d.done = 1'b1;
                        st_d.state = HS_READY;
                    end
                end
                HS_SLEEP: begin
                    // least pulse width, then release when no longer asked
                    if (st_q.cnt >= PD_PULSE_CYC && !sleepReq) begin
                        st_d.pd = 1'b0;
                        st_d.state = HS_WAKE;
                        st_d.cnt = 17'h00001;
                    end
                end
                HS_RESET: begin
                    if (st_q.cnt >= RST_PULSE_CYC) begin
                        st_d.rstN = 1'b1;
                        st_d.state = HS_READY;
                    end
                end
                default: begin
                    st_d.state = HS_OFF;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_q.state <= HS_OFF;
            st_q.cnt <= '0;
            st_q.pd <= 1'b1;
            st_q.rstN <= 1'b0;
            st_q.wr <= 1'b0;
            st_q.rd <= 1'b0;
            st_q.addr <= 8'h00;
            st_q.wdata <= 8'h00;
            st_q.rdata <= 8'h00;
            st_q.done <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // pin and user outputs
    assign link.powerDownPin = st_q.pd;
    assign link.resetPinN = st_q.rstN;
    assign link.regWr = st_q.wr;
    assign link.regRd = st_q.rd;
    assign link.regAddr = st_q.addr;
    assign link.regWdata = st_q.wdata;
    assign usrReady = (st_q.state == HS_READY) && supplyUp;
    assign usrRdata = st_q.rdata;
    assign usrDone = st_q.done;
    assign wakeIrq = link.irqPin;
endmodule : pws_host

//--- verification/pws_link_chk.sv
`timescale 1ns/100ps
// watches the pins between host and device ends
module pws_link_chk
    import pws_pkg::*;
#(
    parameter logic [16:0] PwrOnCyc = PWR_ON_CYC,
    parameter logic [16:0] WakeCyc = WAKE_CYC,
    parameter logic [16:0] StableCyc = STABLE_CYC
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic powerDownPin,
    input wire logic resetPinN,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regAck,
    input wire logic irqOe,
    input wire logic irqPin,
    input wire logic clockOutPin
);
    logic [16:0] pdCnt_q; // cycles power-down held
    logic [16:0] rstCnt_q; // cycles reset held
    logic [16:0] relCnt_q; // cycles since power-down release, saturating
    logic por_q; // power-on sequence not yet finished
    logic [7:0] cfg_q; // shadow of the interrupt pin config
    logic wakeEn_q; // shadow of the wake enable bit

    // counters and register shadows follow the pins
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pdCnt_q <= 17'h00000;
            rstCnt_q <= 17'h00000;
            relCnt_q <= 17'h00000;
            por_q <= 1'b1;
            cfg_q <= 8'h00;
            wakeEn_q <= 1'b0;
        end else begin
            pdCnt_q <= powerDownPin ? pdCnt_q + 17'h00001 : 17'h00000;
            rstCnt_q <= resetPinN ? 17'h00000 : rstCnt_q + 17'h00001;
            if (powerDownPin) begin
                relCnt_q <= 17'h00000;
            end else if (relCnt_q != 17'h1FFFF) begin
                relCnt_q <= relCnt_q + 17'h00001;
            end
            if (resetPinN) begin
                por_q <= 1'b0;
            end
            // reset pin clears the device registers
            if (!resetPinN) begin
                cfg_q <= 8'h00;
                wakeEn_q <= 1'b0;
            end else if (regWr && regAddr == ADDR_CONFIG_IRQ) begin
                cfg_q <= regWdata;
            end else if (regWr && regAddr == ADDR_WAKE_EN) begin
                wakeEn_q <= regWdata[WAKE_EN_BIT];
            end
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_req;
        regWr || regRd;
    endsequence
    sequence s_awake;
        !powerDownPin && relCnt_q > WakeCyc + 17'h00002;
    endsequence

    property p_porPd;
        por_q && !resetPinN |-> powerDownPin;
    endproperty
    property p_porPdHold;
        $fell(powerDownPin) && por_q |-> pdCnt_q >= PwrOnCyc;
    endproperty
    property p_porRst;
        $rose(resetPinN) && por_q |-> rstCnt_q >= PwrOnCyc;
    endproperty
    property p_rstPulse;
        $rose(resetPinN) && !por_q |-> rstCnt_q >= RST_PULSE_CYC;
    endproperty
    property p_pdPulse;
        $fell(powerDownPin) && !por_q |-> pdCnt_q >= PD_PULSE_CYC;
    endproperty
    property p_busWait;
        s_req |-> relCnt_q >= StableCyc + BUS_RDY_CYC;
    endproperty
    property p_ack;
        s_req |=> regAck ##1 !regAck;
    endproperty
    property p_clkQuiet;
        !powerDownPin && relCnt_q > 17'h00002 && relCnt_q < WakeCyc - 17'h00002 |-> !clockOutPin;
    endproperty
    property p_clkRun;
        s_awake ##0 clockOutPin |=> !clockOutPin;
    endproperty
    property p_irqPush;
        !cfg_q[CFG_DRV_BIT] |-> irqOe;
    endproperty
    property p_wakeIrq;
        wakeEn_q && !powerDownPin && relCnt_q == WakeCyc + 17'h00002 |-> irqPin == cfg_q[CFG_POL_BIT];
    endproperty

    a_porPd: assert property (p_porPd)
        else $error("power-down low during power-on reset");
    a_porPdHold: assert property (p_porPdHold)
        else $error("power-down released too early after power on");
    a_porRst: assert property (p_porRst)
        else $error("reset released too early after power on");
    a_rstPulse: assert property (p_rstPulse)
        else $error("reset pulse too short");
    a_pdPulse: assert property (p_pdPulse)
        else $error("power-down pulse too short");
    a_busWait: assert property (p_busWait)
        else $error("access before oscillator settle wait");
    a_ack: assert property (p_ack)
        else $error("access not answered in one cycle");
    a_clkQuiet: assert property (p_clkQuiet)
        else $error("clock output active before wake delay");
    a_clkRun: assert property (p_clkRun)
        else $error("clock output stuck high while awake");
    a_irqPush: assert property (p_irqPush)
        else $error("push-pull interrupt pin not driven");
    a_wakeIrq: assert property (p_wakeIrq)
        else $error("wake interrupt not at active level");
endmodule : pws_link_chk

//--- verification/power_down_wake_sequencer_tb.sv
`timescale 1ns/100ps
// drives the host user port, watches device status and the pins
module power_down_wake_sequencer_tb;
    import pws_pkg::*;
    localparam logic [16:0] TbPwr = 17'h0000A; // short power-on hold
    localparam logic [16:0] TbWake = 17'h00014; // short wake delay
    localparam logic [16:0] TbStable = 17'h00018; // short settle delay
    logic mclk, nrst, supplyUp, sleepReq, resetReq, usrWr, usrRd, usrReady, usrDone, wakeIrq;
    logic [7:0] usrAddr, usrWdata, usrRdata, cfg;
    logic clockOutEnable, lowPower, clocksRunning, oscStable, en, prev;
    int errors, comparisons;

    pws_link_if link ();
    pws_host #(.PwrOnCyc(TbPwr), .StableCyc(TbStable)) u_pws_host (.mclk(mclk), .nrst(nrst),
        .link(link), .supplyUp(supplyUp), .sleepReq(sleepReq), .resetReq(resetReq),
        .usrWr(usrWr), .usrRd(usrRd), .usrAddr(usrAddr), .usrWdata(usrWdata),
        .usrReady(usrReady), .usrRdata(usrRdata), .usrDone(usrDone), .wakeIrq(wakeIrq));
    pws_device #(.WakeCyc(TbWake), .StableCyc(TbStable)) u_pws_device (.mclk(mclk),
        .nrst(nrst), .link(link), .clockOutEnable(clockOutEnable), .lowPower(lowPower),
        .clocksRunning(clocksRunning), .oscStable(oscStable));
    pws_link_chk #(.PwrOnCyc(TbPwr), .WakeCyc(TbWake), .StableCyc(TbStable)) u_pws_link_chk (
        .mclk(mclk), .nrst(nrst), .powerDownPin(link.powerDownPin), .resetPinN(link.resetPinN),
        .regWr(link.regWr), .regRd(link.regRd), .regAddr(link.regAddr),
        .regWdata(link.regWdata), .regAck(link.regAck), .irqOe(link.irqOe),
        .irqPin(link.irqPin), .clockOutPin(link.clockOutPin));

    // compare and count
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // verdict and end of run
    task automatic summarize();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // bounded wait for the host to accept requests
    task automatic waitReady();
        int n;
        n = 0;
        while (usrReady !== 1'b1 && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        check("usrReady", 8'(usrReady), 8'h01);
    endtask : waitReady

    // one register access through the host user port
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        int n;
        waitReady();
        usrWr = wr;
        usrRd = !wr;
        usrAddr = a;
        usrWdata = d;
        @(negedge mclk);
        usrWr = 1'b0;
        usrRd = 1'b0;
        n = 0;
        while (usrDone !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        check("usrDone", 8'(usrDone), 8'h01);
        q = usrRdata;
    endtask : access

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        access(1'b1, a, d, q);
    endtask : wr

    task automatic rdChk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        access(1'b0, a, 8'h00, q);
        check(what, q, exp);
    endtask : rdChk

    // sleep request, then time the wake steps at the device
    task automatic sleepWake();
        int n;
        sleepReq = 1'b1;
        n = 0;
        while (link.powerDownPin !== 1'b1 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        repeat (3) @(negedge mclk);
        check("lowPower", 8'(lowPower), 8'h01);
        check("clockOutPin", 8'(link.clockOutPin), 8'h00);
        sleepReq = 1'b0;
        n = 0;
        while (link.powerDownPin !== 1'b0 && n < 1000) begin
            @(negedge mclk);
            n++;
        end
        n = 0;
        while (clocksRunning !== 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        check("wakeCycles", 8'(n), 8'(TbWake));
        check("wakeIrq", 8'(wakeIrq), 8'(en ? cfg[0] : !cfg[0]));
        while (oscStable !== 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        check("stableCycles", 8'(n), 8'(TbStable));
        prev = link.clockOutPin;
        @(negedge mclk);
        check("clockOutToggle", 8'(link.clockOutPin), 8'(!prev));
    endtask : sleepWake

    // free-running clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // watchdog against a hang
    initial begin
        #(30000 * 25);
        errors++;
        $display("BAD watchdog expected finish seen hang");
        summarize();
    end

    // test sequence
    initial begin
        nrst = 1'b0;
        supplyUp = 1'b0;
        sleepReq = 1'b0;
        resetReq = 1'b0;
        usrWr = 1'b0;
        usrRd = 1'b0;
        usrAddr = 8'h00;
        usrWdata = 8'h00;
        clockOutEnable = 1'b1;
        errors = 0;
        comparisons = 0;
        repeat (2) @(negedge mclk);
        nrst = 1'b1;
        @(negedge mclk);
        supplyUp = 1'b1;
        waitReady();
        check("oscStableAtReady", 8'(oscStable), 8'h01);
        rdChk("cfgReset", ADDR_CONFIG_IRQ, CONFIG_IRQ_RST);
        rdChk("wakeReset", ADDR_WAKE_EN, WAKE_EN_RST);
        rdChk("unmapped", 8'h33, 8'h00);
        wr(8'h33, 8'hFF);
        rdChk("cfgAfterUnmapped", ADDR_CONFIG_IRQ, 8'h00);
        $display("test power-on and registers done");
        // every pin config with wake enabled, then one with it off
        for (int i = 0; i < 5; i++) begin
            cfg = 8'(i & 3);
            en = (i < 4);
            wr(ADDR_CONFIG_IRQ, cfg);
            rdChk("cfg", ADDR_CONFIG_IRQ, cfg);
            check("irqIdle", 8'(wakeIrq), 8'(!cfg[0]));
            wr(ADDR_WAKE_EN, {7'h20, en});
            sleepWake();
            rdChk("wakePending", ADDR_WAKE_EN, {en, 6'h20, en});
            rdChk("wakeCleared", ADDR_WAKE_EN, {1'b0, 6'h20, en});
            check("irqCleared", 8'(wakeIrq), 8'(!cfg[0]));
            $display("test wake with config %h done", cfg);
        end
        // reset pulse clears the device registers
        wr(ADDR_CONFIG_IRQ, 8'h03);
        resetReq = 1'b1;
        for (int n = 0; n < 50 && link.resetPinN !== 1'b0; n++) @(negedge mclk);
        resetReq = 1'b0;
        rdChk("cfgAfterReset", ADDR_CONFIG_IRQ, 8'h00);
        rdChk("wakeAfterReset", ADDR_WAKE_EN, 8'h00);
        clockOutEnable = 1'b0;
        repeat (2) @(negedge mclk);
        check("clockOutOff", 8'(link.clockOutPin), 8'h00);
        $display("test reset pulse and clock output done");
        // supply drop and a mid-run reset bring both ends back to power-on
        supplyUp = 1'b0;
        @(negedge mclk);
        check("pdOnSupplyDrop", 8'(link.powerDownPin), 8'h01);
        nrst = 1'b0;
        repeat (2) @(negedge mclk);
        nrst = 1'b1;
        @(negedge mclk);
        check("lowPowerAfterReset", 8'(lowPower), 8'h01);
        check("irqAfterReset", 8'(wakeIrq), 8'h01);
        supplyUp = 1'b1;
        waitReady();
        check("oscStableAgain", 8'(oscStable), 8'h01);
        rdChk("cfgAfterPowerOn", ADDR_CONFIG_IRQ, CONFIG_IRQ_RST);
        $display("test supply drop and reset done");
        summarize();
    end
endmodule : power_down_wake_sequencer_tb
